// ==== common/galf_regs.vh ====
// register offsets, field positions, reset values and timing counts of the gas alarm block
`ifndef GALF_REGS_VH
`define GALF_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define GALF_CTRL_OFS      8'h00
`define GALF_THRESH_OFS    8'h04
`define GALF_FSCALE_OFS    8'h08
`define GALF_DBAND_OFS     8'h0C
`define GALF_DWELL_OFS     8'h10
`define GALF_MEAS_OFS      8'h14
`define GALF_STATUS_OFS    8'h18
`define GALF_FAULT_OFS     8'h1C
`define GALF_WARN_OFS      8'h20

// ****************************************
// control and status fields
// ****************************************
`define GALF_CTRL_DIR      0
`define GALF_CTRL_RELAY    1
`define GALF_CTRL_BLINK    2
`define GALF_CTRL_LOWFLOW  3
`define GALF_ST_ALARM      0
`define GALF_ST_COND       1
`define GALF_ST_RELAY      2
`define GALF_ST_MENU       3

// ****************************************
// fault and warning bit positions
// ****************************************
`define GALF_F_E10         0
`define GALF_F_E11         1
`define GALF_F_E12         2
`define GALF_F_E13         3
`define GALF_F_E14         4
`define GALF_F_E20         5
`define GALF_F_E21         6
`define GALF_F_E22         7
`define GALF_F_E23         8
`define GALF_F_E30         9
`define GALF_F_E31         10
`define GALF_F_E32         11
`define GALF_F_E34         12
`define GALF_W_W00         0
`define GALF_W_W01         1
`define GALF_W_W02         2

// ****************************************
// reset values and limits
// ****************************************
`define GALF_THRESH_RST    16'h0001
`define GALF_FSCALE_RST    16'h0064
`define GALF_DBAND_RST     16'h0000
`define GALF_DWELL_RST     6'h00
`define GALF_DWELL_MAX     6'h3C
`define GALF_FLOW_HI_PCT   16'h0078
`define GALF_FLOW_LOW_ML   16'h00FA
`define GALF_PYRO_LO_MA    16'h0064
`define GALF_PYRO_HI_MA    16'h0384

// ****************************************
// timing
// ****************************************
`define GALF_SEC_NS        1000000000
`define GALF_CLK_NS        50
`define GALF_TICK_CYCLES   (`GALF_SEC_NS / `GALF_CLK_NS)

`endif

// ==== dv/galf_alarm_monitor.sv ====
// concurrent checks on the ports of the gas alarm block
`timescale 1ns/1ns
module galf_alarm_monitor (
	// clock and reset
	input wire        hclk,
	input wire        hresetn,
	input wire        ce,
	// watched inputs
	input wire        cart_present,
	input wire        main_eeprom_ok,
	input wire        flow_sensor_ok,
	input wire        cal_expired,
	input wire [15:0] flow_pct,
	input wire [15:0] pyro_ma,
	// watched outputs
	input wire        relay_out,
	input wire        alarm_out,
	input wire        fault_any,
	input wire        warn_any,
	input wire        menu_mode,
	input wire [2:0]  menu_item
);
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_relay_needs_alarm: assert property (relay_out |-> alarm_out)
		else $error("relay contact on without alarm");
	a_cart_missing: assert property ((!cart_present && ce) [*5] |=> fault_any)
		else $error("missing cartridge not flagged");
	a_eeprom_missing: assert property ((!main_eeprom_ok && ce) [*5] |=> fault_any)
		else $error("missing main eeprom not flagged");
	a_flow_high: assert property (($signed(flow_pct) > 16'sh0078 && flow_sensor_ok && ce) [*5]
		|=> fault_any)
		else $error("high flow not flagged");
	a_pyro_low: assert property ((pyro_ma < 16'h0064 && ce) [*3] |=> fault_any)
		else $error("low pyrolyzer current not flagged");
	a_cal_warn: assert property ((cal_expired && ce) [*5] |=> warn_any)
		else $error("expired calibration not warned");
	a_menu_flag: assert property (menu_mode == (menu_item != 3'h0))
		else $error("menu flag disagrees with item");
	a_menu_step: assert property (menu_item != $past(menu_item)
		|-> menu_item == $past(menu_item) + 3'h1)
		else $error("menu item skipped or went back");
endmodule // galf_alarm_monitor

// ==== dv/galf_front.sv ====
// far-side model: cartridge pins, flow, pyrolyzer and measurement source
`timescale 1ns/1ns
module galf_front (
	// control from the bench
	input  wire        hclk,
	input  wire [3:0]  fault_code,
	input  wire        hunt,
	input  wire [15:0] meas_lvl,
	// pins toward the block
	output reg  [15:0] meas_value,
	output reg         meas_valid,
	output wire [15:0] flow_pct,
	output wire [15:0] flow_ml,
	output wire [15:0] pyro_ma,
	output wire        cart_present,
	output wire        cart_comm_ok,
	output wire        sensor_fitted,
	output wire        cart_eeprom_ok,
	output wire        selftest_ok,
	output wire        flow_sensor_ok,
	output wire        main_eeprom_ok,
	output wire        time_valid,
	output wire        cal_expired,
	output wire        mfg_date_set
);
	// ****************************************
	// one bad condition at a time
	// ****************************************
	reg [1:0] cnt = 2'h0;
	reg       up  = 1'b0;
	assign cart_present   = fault_code != 4'h1;
	assign cart_comm_ok   = fault_code != 4'h2;
	assign sensor_fitted  = fault_code != 4'h3;
	assign cart_eeprom_ok = fault_code != 4'h4;
	assign selftest_ok    = fault_code != 4'h5;
	assign flow_sensor_ok = fault_code != 4'h6;
	assign flow_pct = (fault_code == 4'h7) ? 16'hFFFF : (fault_code == 4'h8) ? 16'h0079 : 16'h0064;
	assign flow_ml  = (fault_code == 4'h9) ? 16'h00F9 : 16'h01F4;
	assign pyro_ma  = (fault_code == 4'hA) ? 16'h0063 : (fault_code == 4'hC) ? 16'h0385 : 16'h01F4;
	assign main_eeprom_ok = fault_code != 4'hB;
	assign time_valid     = fault_code != 4'hD;
	assign cal_expired    = fault_code == 4'hE;
	assign mfg_date_set   = fault_code != 4'hF;
	// sample every fourth cycle; hunting flips direction on each sample
	always @(posedge hclk)
	begin
		cnt <= cnt + 2'h1;
		meas_valid <= (cnt == 2'h3);
		if (cnt == 2'h3)
			up <= !up;
		meas_value <= (hunt && up) ? meas_lvl + 16'h0002 : meas_lvl;
	end
endmodule // galf_front

// ==== dv/galf_tb.sv ====
// self-checking bench for the gas alarm block
`timescale 1ns/1ns
`include "galf_regs.vh"
module testbench;
	// ****************************************
	// signals, clock, instances
	// ****************************************
	reg         hclk = 1'b0;
	reg         hresetn = 1'b0;
	reg         ce = 1'b1;
	reg         hsel = 1'b0;
	reg  [31:0] haddr = 32'h0;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [2:0]  hsize = 3'h2;
	reg  [31:0] hwdata = 32'h0;
	reg         key_up = 1'b0;
	reg         key_down = 1'b0;
	reg         function_key = 1'b0;
	reg  [3:0]  fc = 4'h0;
	reg         hunt = 1'b0;
	reg  [15:0] lvl = 16'h0000;
	wire [31:0] hrdata;
	wire        hreadyout, hresp, meas_valid, relay_out, alarm_out, fault_any, warn_any;
	wire        menu_mode, cart_present, cart_comm_ok, sensor_fitted, cart_eeprom_ok;
	wire        selftest_ok, flow_sensor_ok, main_eeprom_ok, time_valid, cal_expired;
	wire        mfg_date_set;
	wire [15:0] meas_value, flow_pct, flow_ml, pyro_ma;
	wire [2:0]  menu_item;
	wire        hready = hreadyout;
	integer     n_fail = 0;
	integer     checked = 0;
	always #25 hclk = !hclk;
	galf_alarm #(.TICK_CYCLES(20), .HUNT_REV(2), .HUNT_SECS(2)) galf_alarm_inst (.*);
	galf_front galf_front_inst (.hclk(hclk), .fault_code(fc), .hunt(hunt), .meas_lvl(lvl),
		.meas_value(meas_value), .meas_valid(meas_valid), .flow_pct(flow_pct),
		.flow_ml(flow_ml), .pyro_ma(pyro_ma), .cart_present(cart_present),
		.cart_comm_ok(cart_comm_ok), .sensor_fitted(sensor_fitted),
		.cart_eeprom_ok(cart_eeprom_ok), .selftest_ok(selftest_ok),
		.flow_sensor_ok(flow_sensor_ok), .main_eeprom_ok(main_eeprom_ok),
		.time_valid(time_valid), .cal_expired(cal_expired), .mfg_date_set(mfg_date_set));
	// ****************************************
	// shared tasks
	// ****************************************
	task give_verdict;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wt(input integer n);
		repeat (n) @(posedge hclk);
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		checked = checked + 1;
		if (g !== e)
		begin
			$display("[FAIL] %0s expected %h seen %h", nm, e, g);
			n_fail = n_fail + 1;
		end
	endtask
	// bounded wait so a stuck bus ends the run
	task hwait;
		integer i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && i < 20)
		begin
			@(posedge hclk);
			i = i + 1;
		end
		if (i >= 20)
		begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	endtask
	task wr(input [31:0] a, input [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		hwait;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
	endtask
	task rc(input string nm, input [31:0] a, input [31:0] e);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		hwait;
		htrans <= 2'h0;
		hwait;
		chk(nm, e, hrdata);
	endtask
	task step(input [15:0] v, input e);
		lvl <= v;
		wt(6);
		chk("alarm_out", {31'h0, e}, {31'h0, alarm_out});
	endtask
	// k: 0 up, 1 down, 2 function
	task press(input integer k);
		key_up <= (k == 0);
		key_down <= (k == 1);
		function_key <= (k == 2);
		wt(4);
		key_up <= 1'b0;
		key_down <= 1'b0;
		function_key <= 1'b0;
		wt(4);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_regs;
		rc("thresh", `GALF_THRESH_OFS, 32'h1);
		rc("dband", `GALF_DBAND_OFS, 32'h0);
		rc("ctrl", `GALF_CTRL_OFS, 32'h0);
		rc("fscale", `GALF_FSCALE_OFS, 32'h64);
		rc("unmapped", 32'h100, 32'h0);
		wr(`GALF_THRESH_OFS, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		rc("thresh", `GALF_THRESH_OFS, 32'h1);
		wr(`GALF_THRESH_OFS, 32'h65);
		rc("thresh", `GALF_THRESH_OFS, 32'h1);
		wr(`GALF_THRESH_OFS, 32'h64);
		rc("thresh", `GALF_THRESH_OFS, 32'h64);
		wr(`GALF_DWELL_OFS, 32'h3D);
		rc("dwell", `GALF_DWELL_OFS, 32'h0);
		wr(`GALF_DWELL_OFS, 32'h3C);
		rc("dwell", `GALF_DWELL_OFS, 32'h3C);
	endtask
	task t_trip;
		wr(`GALF_DWELL_OFS, 32'h0);
		wr(`GALF_THRESH_OFS, 32'h32);
		wr(`GALF_DBAND_OFS, 32'h5);
		wr(`GALF_CTRL_OFS, 32'h2);
		step(16'd54, 1'b0);
		step(16'd55, 1'b1);
		step(16'd46, 1'b1);
		step(16'd44, 1'b0);
		wr(`GALF_CTRL_OFS, 32'h3);
		step(16'd56, 1'b0);
		step(16'd45, 1'b1);
		step(16'd54, 1'b1);
		step(16'd56, 1'b0);
	endtask
	task t_dwell;
		wr(`GALF_CTRL_OFS, 32'h2);
		wr(`GALF_DWELL_OFS, 32'h3);
		step(16'd40, 1'b0);
		step(16'd60, 1'b0);
		wt(24);
		chk("alarm_out", 32'h0, {31'h0, alarm_out});
		step(16'd40, 1'b0);
		step(16'd60, 1'b0);
		wt(24);
		chk("alarm_out", 32'h0, {31'h0, alarm_out});
		wt(40);
		chk("alarm_out", 32'h1, {31'h0, alarm_out});
	endtask
	task t_relay;
		integer n;
		reg     prev;
		n = 0;
		wr(`GALF_DWELL_OFS, 32'h0);
		wr(`GALF_CTRL_OFS, 32'h6);
		wt(10);
		prev = relay_out;
		repeat (100)
		begin
			@(posedge hclk);
			if (relay_out !== prev)
				n = n + 1;
			prev = relay_out;
		end
		chk("toggles", 32'h5, n);
		ce <= 1'b0;
		wt(1);
		prev = relay_out;
		wt(60);
		chk("frozen relay", {31'h0, prev}, {31'h0, relay_out});
		ce <= 1'b1;
		wr(`GALF_CTRL_OFS, 32'h0);
		wt(4);
		chk("relay_out", 32'h0, {31'h0, relay_out});
		wr(`GALF_CTRL_OFS, 32'h2);
		wt(4);
		chk("relay_out", 32'h1, {31'h0, relay_out});
	endtask
	task t_keys;
		press(2);
		chk("menu_item", 32'h1, {29'h0, menu_item});
		press(0);
		press(2);
		press(2);
		press(1);
		press(2);
		chk("menu_item", 32'h4, {29'h0, menu_item});
		press(0);
		press(0);
		press(1);
		press(2);
		press(2);
		press(0);
		press(2);
		chk("menu_item", 32'h7, {29'h0, menu_item});
		press(2);
		chk("menu_mode", 32'h0, {31'h0, menu_mode});
		rc("thresh", `GALF_THRESH_OFS, 32'h33);
		rc("dwell", `GALF_DWELL_OFS, 32'h1);
		rc("dband", `GALF_DBAND_OFS, 32'h4);
		rc("ctrl", `GALF_CTRL_OFS, 32'h6);
	endtask
	// low flow check on so that the ml limit is live
	task t_faults;
		integer    c;
		reg [31:0] ef;
		reg [31:0] ew;
		wr(`GALF_CTRL_OFS, 32'h8);
		for (c = 1; c < 16; c = c + 1)
		begin
			fc <= c[3:0];
			ef = (c < 13) ? 32'h1 << (c - 1) : 32'h0;
			ew = (c > 12) ? 32'h1 << (c - 13) : 32'h0;
			wt(8);
			rc("fault", `GALF_FAULT_OFS, ef);
			rc("warn", `GALF_WARN_OFS, ew);
			chk("any", {30'h0, c > 12, c < 13}, {30'h0, warn_any, fault_any});
		end
		fc <= 4'h0;
		hunt <= 1'b1;
		wt(100);
		rc("fault", `GALF_FAULT_OFS, 32'h1000);
		hunt <= 1'b0;
	endtask
	initial
	begin
		wt(16);
		hresetn <= 1'b1;
		wt(8);
		t_regs;
		t_trip;
		t_dwell;
		t_relay;
		t_keys;
		t_faults;
		give_verdict;
	end
endmodule // testbench
bind galf_alarm galf_alarm_monitor galf_alarm_monitor_inst (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .cart_present(cart_present), .main_eeprom_ok(main_eeprom_ok),
	.flow_sensor_ok(flow_sensor_ok), .cal_expired(cal_expired), .flow_pct(flow_pct),
	.pyro_ma(pyro_ma), .relay_out(relay_out), .alarm_out(alarm_out), .fault_any(fault_any),
	.warn_any(warn_any), .menu_mode(menu_mode), .menu_item(menu_item));

// ==== hdl/galf_alarm.v ====
// second-level gas alarm evaluation, relay drive, key menu and fault/warning logic
`timescale 1ns/1ns
`include "galf_regs.vh"

// Functional notes
// - threshold limited to 1 through full scale
// - rising or falling trip direction
// - rising: set at or above thr+db, release below thr-db
// - falling: set at or below thr-db, release above thr+db
// - dead band resets to zero
// - dwell delay limited to 0..60 seconds
// - each key press steps dwell one second
// - alarm only after condition held full dwell
// - relay enable gates the contact
// - optional one second contact blinking
// - function key at end commits, returns menu
// - E-10 cartridge absent or defective
// - E-11 cartridge communication lost
// - E-12, E-13, E-14 cartridge faults
// - E-20 flow sensor not running
// - E-21 flow below 0%, E-22 above 120%
// - E-23 low flow below 250 ml
// - E-30 pyrolyzer under 100 mA, E-32 over 900 mA
// - E-31 main eeprom not detected
// - E-34 measurement hunting continuously
// - W-00, W-01, W-02 warnings

module galf_alarm #(
	parameter TICK_CYCLES = `GALF_TICK_CYCLES,
	parameter HUNT_REV    = 4,
	parameter HUNT_SECS   = 10
) (
	// clock, reset, enable
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        ce,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// measurement front end, same clock
	input  wire [15:0] meas_value,
	input  wire        meas_valid,
	input  wire [15:0] flow_pct,
	input  wire [15:0] flow_ml,
	input  wire [15:0] pyro_ma,
	// asynchronous status pins
	input  wire        cart_present,
	input  wire        cart_comm_ok,
	input  wire        sensor_fitted,
	input  wire        cart_eeprom_ok,
	input  wire        selftest_ok,
	input  wire        flow_sensor_ok,
	input  wire        main_eeprom_ok,
	input  wire        time_valid,
	input  wire        cal_expired,
	input  wire        mfg_date_set,
	// front panel keys
	input  wire        key_up,
	input  wire        key_down,
	input  wire        function_key,
	// outputs
	output reg         relay_out,
	output reg         alarm_out,
	output reg         fault_any,
	output reg         warn_any,
	output reg         menu_mode,
	output reg  [2:0]  menu_item
);

	// ****************************************
	// local codes
	// ****************************************
	localparam NPIN = 13;
	localparam [2:0] IT_MENU = 3'h0, IT_THR = 3'h1, IT_DIR = 3'h2, IT_DB = 3'h3,
		IT_DWELL = 3'h4, IT_RELAY = 3'h5, IT_BLINK = 3'h6, IT_END = 3'h7;

	// ****************************************
	// pin synchronisers
	// ****************************************
	wire [NPIN-1:0] pin_raw = {function_key, key_down, key_up, mfg_date_set, cal_expired,
		time_valid, main_eeprom_ok, flow_sensor_ok, selftest_ok, cart_eeprom_ok,
		sensor_fitted, cart_comm_ok, cart_present};
	wire [NPIN-1:0] pin_s;
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1)
		begin : g_sync
			reg s1_reg;
			reg s2_reg;
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end
				else if (ce)
				begin
					s1_reg <= pin_raw[gi];
					s2_reg <= s1_reg;
				end
			end
			assign pin_s[gi] = s2_reg;
		end
	endgenerate

	// ****************************************
	// state
	// ****************************************
	reg [3:0]  ctrl_reg;
	reg [15:0] thresh_reg;
	reg [15:0] fscale_reg;
	reg [15:0] dband_reg;
	reg [5:0]  dwell_reg;
	reg [7:0]  a_addr_reg;
	reg        a_wr_reg;
	reg [31:0] tick_cnt_reg;
	reg        tick_reg;
	reg        cond_reg;
	reg        alarm_reg;
	reg [5:0]  dwell_cnt_reg;
	reg [31:0] dw_sub_reg;
	reg        blink_ph_reg;
	reg [2:0]  keys_d_reg;
	reg [2:0]  item_reg;
	reg [15:0] e_thr_reg;
	reg [15:0] e_db_reg;
	reg [5:0]  e_dwell_reg;
	reg [2:0]  e_flags_reg;
	reg [15:0] meas_prev_reg;
	reg [1:0]  last_dir_reg;
	reg [7:0]  rev_cnt_reg;
	reg [7:0]  hunt_sec_reg;
	reg [12:0] fault_reg;
	reg [2:0]  warn_reg;

	wire [2:0] key_rise = pin_s[12:10] & ~keys_d_reg;
	wire       k_up     = key_rise[0];
	wire       k_dn     = key_rise[1];
	wire       k_fn     = key_rise[2];
	wire       commit   = k_fn && (item_reg == IT_END);

	// ****************************************
	// ahb-lite decode
	// ****************************************
	wire a_take = hsel && hready && htrans[1];
	wire a_hit  = (haddr[31:8] == 24'h000000);
	wire d_wr   = a_wr_reg;
	wire [15:0] wd16 = hwdata[15:0];

	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h00000000;
		if (a_hit)
		begin
			case (haddr[7:0])
				`GALF_CTRL_OFS:   rd_mux = {28'h0000000, ctrl_reg};
				`GALF_THRESH_OFS: rd_mux = {16'h0000, thresh_reg};
				`GALF_FSCALE_OFS: rd_mux = {16'h0000, fscale_reg};
				`GALF_DBAND_OFS:  rd_mux = {16'h0000, dband_reg};
				`GALF_DWELL_OFS:  rd_mux = {26'h0000000, dwell_reg};
				`GALF_MEAS_OFS:   rd_mux = {16'h0000, meas_value};
				`GALF_STATUS_OFS: rd_mux = {28'h0000000, menu_mode, relay_out, cond_reg,
					alarm_reg};
				`GALF_FAULT_OFS:  rd_mux = {19'h00000, fault_reg};
				`GALF_WARN_OFS:   rd_mux = {29'h00000000, warn_reg};
				default:          rd_mux = 32'h00000000;
			endcase
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			a_addr_reg <= 8'hFF;
			a_wr_reg   <= 1'b0;
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
		else if (ce)
		begin
			// zero wait states; read data is latched in the address phase
			a_wr_reg   <= a_take && hwrite && a_hit;
			a_addr_reg <= haddr[7:0];
			if (a_take && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg   <= 4'h0;
			thresh_reg <= `GALF_THRESH_RST;
			fscale_reg <= `GALF_FSCALE_RST;
			dband_reg  <= `GALF_DBAND_RST;
			dwell_reg  <= `GALF_DWELL_RST;
		end
		else if (ce)
		begin
			if (commit)
			begin
				// key commit wins over a bus write in the same cycle
				thresh_reg <= e_thr_reg;
				dband_reg  <= e_db_reg;
				dwell_reg  <= e_dwell_reg;
				ctrl_reg   <= {ctrl_reg[3], e_flags_reg};
			end
			else if (d_wr)
			begin
				case (a_addr_reg)
					`GALF_CTRL_OFS:   ctrl_reg <= hwdata[3:0];
					`GALF_THRESH_OFS:
						if (wd16 != 16'h0000 && wd16 <= fscale_reg)
							thresh_reg <= wd16;
					`GALF_FSCALE_OFS:
						if (wd16 != 16'h0000 && wd16 >= thresh_reg)
							fscale_reg <= wd16;
					`GALF_DBAND_OFS:  dband_reg <= wd16;
					`GALF_DWELL_OFS:
						if (hwdata[31:6] == 26'h0000000 && hwdata[5:0] <= `GALF_DWELL_MAX)
							dwell_reg <= hwdata[5:0];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// key menu
	// ****************************************
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			keys_d_reg  <= 3'h0;
			item_reg    <= IT_MENU;
			e_thr_reg   <= `GALF_THRESH_RST;
			e_db_reg    <= `GALF_DBAND_RST;
			e_dwell_reg <= `GALF_DWELL_RST;
			e_flags_reg <= 3'h0;
		end
		else if (ce)
		begin
			keys_d_reg <= pin_s[12:10];
			if (k_fn)
			begin
				item_reg <= item_reg + 3'h1; // end wraps to menu mode
				if (item_reg == IT_MENU)
				begin
					e_thr_reg   <= thresh_reg;
					e_db_reg    <= dband_reg;
					e_dwell_reg <= dwell_reg;
					e_flags_reg <= ctrl_reg[2:0];
				end
			end
			else if (k_up || k_dn)
			begin
				case (item_reg)
					IT_THR:
						if (k_up && e_thr_reg < fscale_reg)
							e_thr_reg <= e_thr_reg + 16'h0001;
						else if (k_dn && e_thr_reg > 16'h0001)
							e_thr_reg <= e_thr_reg - 16'h0001;
					IT_DIR:   e_flags_reg[`GALF_CTRL_DIR] <= ~e_flags_reg[`GALF_CTRL_DIR];
					IT_DB:
						if (k_up && e_db_reg != 16'hFFFF)
							e_db_reg <= e_db_reg + 16'h0001;
						else if (k_dn && e_db_reg != 16'h0000)
							e_db_reg <= e_db_reg - 16'h0001;
					IT_DWELL:
						if (k_up && e_dwell_reg < `GALF_DWELL_MAX)
							e_dwell_reg <= e_dwell_reg + 6'h01;
						else if (k_dn && e_dwell_reg != 6'h00)
							e_dwell_reg <= e_dwell_reg - 6'h01;
					IT_RELAY: e_flags_reg[`GALF_CTRL_RELAY] <= ~e_flags_reg[`GALF_CTRL_RELAY];
					IT_BLINK: e_flags_reg[`GALF_CTRL_BLINK] <= ~e_flags_reg[`GALF_CTRL_BLINK];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// seconds tick
	// ****************************************
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg     <= 1'b0;
		end
		else if (ce)
		begin
			tick_reg <= (tick_cnt_reg == TICK_CYCLES - 1);
			if (tick_cnt_reg == TICK_CYCLES - 1)
				tick_cnt_reg <= 32'h00000000;
			else
				tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
		end
	end

	// ****************************************
	// trip condition, dwell, relay
	// ****************************************
	// 17-bit sums avoid wrap when threshold plus dead band passes full range
	wire [16:0] thr_hi  = {1'b0, thresh_reg} + {1'b0, dband_reg};
	wire [16:0] meas_hi = {1'b0, meas_value} + {1'b0, dband_reg};
	wire [16:0] meas17  = {1'b0, meas_value};
	wire [16:0] thr17   = {1'b0, thresh_reg};
	wire        falling = ctrl_reg[`GALF_CTRL_DIR];
	wire        set_c   = falling ? (meas_hi <= thr17) : (meas17 >= thr_hi);
	wire        clr_c   = falling ? (meas17 > thr_hi) : (meas_hi < thr17);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cond_reg      <= 1'b0;
			alarm_reg     <= 1'b0;
			dwell_cnt_reg <= 6'h00;
			dw_sub_reg    <= 32'h00000000;
			blink_ph_reg  <= 1'b1;
			relay_out     <= 1'b0;
			alarm_out     <= 1'b0;
		end
		else if (ce)
		begin
			if (!cond_reg && set_c)
				cond_reg <= 1'b1;
			else if (cond_reg && clr_c)
				cond_reg <= 1'b0;
			// a dropped condition restarts the dwell count
			// own sub-second count: the shared tick would make the first second partial
			if (!cond_reg)
			begin
				alarm_reg     <= 1'b0;
				dwell_cnt_reg <= 6'h00;
				dw_sub_reg    <= 32'h00000000;
			end
			else if (!alarm_reg)
			begin
				if (dwell_cnt_reg >= dwell_reg)
					alarm_reg <= 1'b1;
				else if (dw_sub_reg == TICK_CYCLES - 1)
				begin
					dw_sub_reg    <= 32'h00000000;
					dwell_cnt_reg <= dwell_cnt_reg + 6'h01;
				end
				else
					dw_sub_reg <= dw_sub_reg + 32'h00000001;
			end
			if (!alarm_reg)
				blink_ph_reg <= 1'b1;
			else if (tick_reg)
				blink_ph_reg <= ~blink_ph_reg;
			alarm_out <= alarm_reg;
			relay_out <= alarm_reg && ctrl_reg[`GALF_CTRL_RELAY] &&
				(!ctrl_reg[`GALF_CTRL_BLINK] || blink_ph_reg);
		end
	end

	// ****************************************
	// hunting detector
	// ****************************************
	wire [1:0] cur_dir = (meas_value > meas_prev_reg) ? 2'h1 :
		(meas_value < meas_prev_reg) ? 2'h2 : 2'h0;
	wire       rev     = meas_valid && cur_dir != 2'h0 && last_dir_reg != 2'h0 &&
		cur_dir != last_dir_reg;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meas_prev_reg <= 16'h0000;
			last_dir_reg  <= 2'h0;
			rev_cnt_reg   <= 8'h00;
			hunt_sec_reg  <= 8'h00;
		end
		else if (ce)
		begin
			if (meas_valid)
			begin
				meas_prev_reg <= meas_value;
				if (cur_dir != 2'h0)
					last_dir_reg <= cur_dir;
			end
			if (tick_reg)
			begin
				rev_cnt_reg <= 8'h00;
				if (rev_cnt_reg >= HUNT_REV[7:0])
				begin
					if (hunt_sec_reg != 8'hFF)
						hunt_sec_reg <= hunt_sec_reg + 8'h01;
				end
				else
					hunt_sec_reg <= 8'h00;
			end
			else if (rev && rev_cnt_reg != 8'hFF)
				rev_cnt_reg <= rev_cnt_reg + 8'h01;
		end
	end

	// ****************************************
	// faults and warnings
	// ****************************************
	reg [12:0] f_next;
	reg [2:0]  w_next;
	always @*
	begin
		f_next = 13'h0000;
		f_next[`GALF_F_E10] = ~pin_s[0];
		f_next[`GALF_F_E11] = pin_s[0] & ~pin_s[1];
		f_next[`GALF_F_E12] = pin_s[0] & ~pin_s[2];
		f_next[`GALF_F_E13] = pin_s[0] & ~pin_s[3];
		f_next[`GALF_F_E14] = pin_s[0] & ~pin_s[4];
		f_next[`GALF_F_E20] = ~pin_s[5];
		f_next[`GALF_F_E21] = pin_s[5] & flow_pct[15];
		f_next[`GALF_F_E22] = pin_s[5] & ~flow_pct[15] & (flow_pct > `GALF_FLOW_HI_PCT);
		f_next[`GALF_F_E23] = pin_s[5] & ctrl_reg[`GALF_CTRL_LOWFLOW] &
			(flow_ml < `GALF_FLOW_LOW_ML);
		f_next[`GALF_F_E30] = (pyro_ma < `GALF_PYRO_LO_MA);
		f_next[`GALF_F_E31] = ~pin_s[6];
		f_next[`GALF_F_E32] = (pyro_ma > `GALF_PYRO_HI_MA);
		f_next[`GALF_F_E34] = (hunt_sec_reg >= HUNT_SECS[7:0]);
		w_next = 3'h0;
		w_next[`GALF_W_W00] = ~pin_s[7];
		w_next[`GALF_W_W01] = pin_s[8];
		w_next[`GALF_W_W02] = ~pin_s[9];
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fault_reg <= 13'h0000;
			warn_reg  <= 3'h0;
			fault_any <= 1'b0;
			warn_any  <= 1'b0;
			menu_mode <= 1'b0;
			menu_item <= 3'h0;
		end
		else if (ce)
		begin
			fault_reg <= f_next;
			warn_reg  <= w_next;
			fault_any <= |f_next;
			warn_any  <= |w_next;
			menu_mode <= (item_reg != IT_MENU);
			menu_item <= item_reg;
		end
	end

endmodule // galf_alarm
